//--- logic/ffe_front_end.sv
// Front end of the floating-point coprocessor: instruction, data, address and maintenance logic.
`timescale 1ns/1ps
`include "ffe_consts.svh"
module ffe_front_end
	import ffe_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic cpu_instr_stb,
	input wire logic cpu_data_stb,
	input wire logic cpu_addr_stb,
	input wire logic [15:0] cpu_buffer_reg,
	input wire logic [15:0] cpu_gr3,
	input wire logic [15:0] cpu_gr4,
	input wire logic [2:0] op_req,
	input wire logic op_stb,
	input wire logic instr_done,
	input wire logic error_evt,
	input wire logic [3:0] error_code,
	input wire logic [7:0] microstate,
	input wire logic [1:0] out_sel,
	input wire logic [1:0] in_sel,
	input wire logic [15:0] obuf,
	input wire logic [9:0] exp_alu,
	input wire logic [59:0] frac_work_in,
	input wire logic [59:0] quot_in,
	input wire logic frac_load,
	input wire logic [7:0] exponent_result_reg,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic [15:0] data_out_mux,
	output logic [15:0] data_in_mux,
	output logic [11:0] instr_exec_reg,
	output logic instr_pending,
	output logic executing,
	output logic [7:0] seq_redirect,
	output logic seq_trap,
	output logic scope_sync,
	output logic [55:0] accumulator_zero,
	output logic [8:0] acc_zero_exp_sign,
	output logic shift_bad
);
	// Register map of the plain register port
	localparam logic [3:0] RA_STATUS = 4'h0;
	localparam logic [3:0] RA_BRK = 4'h1;
	localparam logic [3:0] RA_EXC_ADDR = 4'h2;
	localparam logic [3:0] RA_EXC_CODE = 4'h3;
	localparam logic [3:0] RA_INSTR = 4'h4;
	localparam logic [3:0] RA_ACC7_HI = 4'h5;

	ffe_state_e state_r;
	logic [2:0] stb_sync_r [3];
	logic [2:0] stb_in;
	logic [2:0] stb_edge;
	logic [15:0] bus_sync1_r, bus_sync2_r;
	logic [11:0] instr_hold_reg_r;
	logic hold_valid_r;
	logic [15:0] cpu_data_reg_r;
	logic [15:0] cpu_instr_addr_reg_r;
	logic [15:0] exception_addr_reg_r;
	logic [15:0] fp_status_reg_r;
	logic [7:0] brk_r;
	logic [55:0] acc_seven_r;
	logic [59:0] frac_r, quot_r;
	logic [55:0] acc0_r;
	logic [8:0] acc0_es_r;
	logic [3:0] sync_cnt_r;
	logic maint_mode_bit;
	logic brk_match;
	logic [15:0] rdata_nxt;
	logic instr_edge, data_edge, addr_edge;
	logic do_shift, do_copy_frac, do_copy_quot, do_load_brk, do_store_status;
	ffe_op_e op;
	ffe_shift_if sh();

	// Buffer word comes from the CPU's timing domain and passes two flops
	// The word is not gray coded: the CPU must hold it steady around its strobe
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bus_sync1_r <= 16'h0000;
			bus_sync2_r <= 16'h0000;
		end else begin
			bus_sync1_r <= cpu_buffer_reg;
			bus_sync2_r <= bus_sync1_r;
		end
	end
	// Strobes pass two flops each; the third flop only serves edge detection
	assign stb_in = {cpu_addr_stb, cpu_data_stb, cpu_instr_stb};
	for (genvar g = 0; g < 3; g++) begin : g_stb_sync
		always_ff @(posedge core_clk or negedge rstn) begin
			if (!rstn) begin
				stb_sync_r[g] <= 3'h0;
			end else begin
				stb_sync_r[g] <= {stb_sync_r[g][1:0], stb_in[g]};
			end
		end
		// Rising edge of the strobe, seen only past the second flop
		assign stb_edge[g] = stb_sync_r[g][1] & ~stb_sync_r[g][2];
	end
	assign instr_edge = stb_edge[0];
	assign data_edge = stb_edge[1];
	assign addr_edge = stb_edge[2];
	assign op = ffe_op_e'(op_req);
	assign do_shift = op_stb && (op == FFE_OP_SHIFT);
	assign do_copy_frac = op_stb && (op == FFE_OP_COPY_FRAC);
	assign do_copy_quot = op_stb && (op == FFE_OP_COPY_QUOT);
	assign do_load_brk = op_stb && (op == FFE_OP_LOAD_BRK);
	assign do_store_status = op_stb && (op == FFE_OP_STORE_STATUS);
	assign maint_mode_bit = fp_status_reg_r[`FFE_MAINT_BIT];

	// Holding register: only the CPU instruction strobe loads it
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			instr_hold_reg_r <= 12'h000;
			hold_valid_r <= 1'b0;
		end else if (instr_edge) begin
			instr_hold_reg_r <= bus_sync2_r[`FFE_INSTR_W-1:0];
			hold_valid_r <= 1'b1;
		end else if (state_r == FFE_ST_START) begin
			hold_valid_r <= 1'b0;
		end
	end

	// Sequencer front: idle -> start -> exec -> ready -> start or idle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= FFE_ST_IDLE;
			instr_exec_reg <= 12'h000;
			executing <= 1'b0;
		end else begin
			case (state_r)
				FFE_ST_IDLE: begin
					if (hold_valid_r) begin
						state_r <= FFE_ST_START;
					end
				end
				FFE_ST_START: begin
					instr_exec_reg <= instr_hold_reg_r;
					state_r <= FFE_ST_EXEC;
					// Registered so the pin never glitches on a state decode
					executing <= 1'b1;
				end
				FFE_ST_EXEC: begin
					if (instr_done) begin
						state_r <= FFE_ST_READY;
						executing <= 1'b0;
					end
				end
				FFE_ST_READY: begin
					// A waiting instruction starts straight away
					state_r <= hold_valid_r ? FFE_ST_START : FFE_ST_IDLE;
				end
				default: begin
					state_r <= FFE_ST_IDLE;
					executing <= 1'b0;
				end
			endcase
		end
	end

	// Data and instruction address from the CPU
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cpu_data_reg_r <= 16'h0000;
			cpu_instr_addr_reg_r <= 16'h0000;
		end else begin
			if (data_edge) begin
				cpu_data_reg_r <= bus_sync2_r;
			end
			if (addr_edge) begin
				cpu_instr_addr_reg_r <= bus_sync2_r;
			end
		end
	end

	// Exception address and accumulator seven
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			exception_addr_reg_r <= 16'h0000;
			acc_seven_r <= 56'h0;
		end else begin
			if (state_r == FFE_ST_START || state_r == FFE_ST_READY) begin
				exception_addr_reg_r <= cpu_instr_addr_reg_r;
			end
			if (error_evt) begin
				// Seven carries no arithmetic, only the exception record
				acc_seven_r[`FFE_SEG_HI:`FFE_SEG_LO] <= exception_addr_reg_r;
				acc_seven_r[`FFE_SEG_LO-1:`FFE_SEG1_LO] <= {12'h000, error_code};
			end
		end
	end

	// Floating status and breakpoint registers; software writes the status word
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fp_status_reg_r <= 16'h0000;
			brk_r <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == RA_STATUS) begin
				fp_status_reg_r <= reg_wdata;
			end
			if (do_load_brk) begin
				brk_r <= cpu_gr3[`FFE_BRK_W-1:0];
			end else if (reg_wr && reg_addr == RA_BRK) begin
				brk_r <= reg_wdata[`FFE_BRK_W-1:0];
			end
		end
	end

	// Breakpoint match trap and scope sync
	assign brk_match = (microstate == brk_r);
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			seq_trap <= 1'b0;
			seq_redirect <= 8'h00;
			scope_sync <= 1'b0;
			sync_cnt_r <= 4'h0;
		end else begin
			seq_trap <= maint_mode_bit & brk_match;
			seq_redirect <= `FFE_MATCH_STATE;
			// Sync is stretched so a scope can trigger on it at any time base
			if (brk_match) begin
				sync_cnt_r <= `FFE_SYNC_LEN;
			end else if (sync_cnt_r != 4'h0) begin
				sync_cnt_r <= sync_cnt_r - 4'h1;
			end
			scope_sync <= brk_match | (sync_cnt_r != 4'h0);
		end
	end

	// Shifter hookup
	assign sh.count = cpu_gr4[`FFE_CNT_W-1:0];
	assign sh.frac_in = frac_r;
	assign sh.quot_in = quot_r;
	ffe_shifter u_shifter (
		.sh(sh)
	);

	// Fraction and quotient working registers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			frac_r <= 60'h0;
			quot_r <= 60'h0;
			shift_bad <= 1'b0;
		end else if (do_shift) begin
			// Unsupported counts leave both registers as they were
			frac_r <= sh.frac_out;
			quot_r <= sh.quot_out;
			shift_bad <= ~sh.supported;
		end else if (frac_load) begin
			frac_r <= frac_work_in;
			quot_r <= quot_in;
		end
	end

	// Diagnostic copies into accumulator zero; the sign bit is never written
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			acc0_r <= 56'h0;
			acc0_es_r <= 9'h000;
		end else if (do_copy_frac) begin
			acc0_r <= {frac_r[`FFE_HID_BIT-1:`FFE_GUARD_HI+1], 1'b0};
			acc0_es_r[`FFE_EXP_W-1:0] <= exponent_result_reg;
		end else if (do_copy_quot) begin
			acc0_r <= {quot_r[`FFE_HID_BIT-1:`FFE_GUARD_HI+1], 1'b0};
			acc0_es_r[`FFE_EXP_W-1:0] <= exponent_result_reg;
		end
	end
	assign accumulator_zero = acc0_r;
	assign acc_zero_exp_sign = acc0_es_r;
	assign instr_pending = hold_valid_r;

	// Output and input multiplexers, registered
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			data_out_mux <= 16'h0000;
			data_in_mux <= 16'h0000;
		end else begin
			case (ffe_osel_e'(out_sel))
				FFE_SRC_OBUF: data_out_mux <= obuf;
				FFE_SRC_STATUS: data_out_mux <= fp_status_reg_r;
				FFE_SRC_ADDR: data_out_mux <= cpu_instr_addr_reg_r;
				FFE_SRC_DATA: data_out_mux <= cpu_data_reg_r;
				default: data_out_mux <= 16'h0000;
			endcase
			if (do_store_status) begin
				data_in_mux <= acc_seven_r[`FFE_SEG_HI:`FFE_SEG_LO];
			end else begin
				case (ffe_isel_e'(in_sel))
					FFE_IN_EXCADDR: data_in_mux <= exception_addr_reg_r;
					FFE_IN_EXP: data_in_mux <= {6'h00, exp_alu};
					FFE_IN_DATA: data_in_mux <= cpu_data_reg_r;
					default: data_in_mux <= 16'h0000;
				endcase
			end
		end
	end

	// Register read port, data one cycle after the strobe
	always_comb begin
		case (reg_addr)
			RA_STATUS: rdata_nxt = fp_status_reg_r;
			RA_BRK: rdata_nxt = {8'h00, brk_r};
			RA_EXC_ADDR: rdata_nxt = exception_addr_reg_r;
			RA_EXC_CODE: rdata_nxt = {12'h000, acc_seven_r[`FFE_SEG1_LO+`FFE_CODE_W-1:`FFE_SEG1_LO]};
			RA_INSTR: rdata_nxt = {3'h0, hold_valid_r, instr_hold_reg_r};
			RA_ACC7_HI: rdata_nxt = acc_seven_r[`FFE_SEG_HI:`FFE_SEG_LO];
			default: rdata_nxt = 16'h0000;
		endcase
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= reg_rd ? rdata_nxt : 16'h0000;
		end
	end
endmodule

//--- logic/ffe_consts.svh
// Constants for the coprocessor front end: widths, field positions and timing.
`ifndef FFE_CONSTS_SVH
`define FFE_CONSTS_SVH
`define FFE_INSTR_W 12
`define FFE_WORD_W 16
`define FFE_FRAC_W 60
`define FFE_ACC_W 56
`define FFE_EXP_W 8
`define FFE_BRK_W 8
`define FFE_CNT_W 7
`define FFE_MAINT_BIT 8
`define FFE_OVF_BIT 59
`define FFE_HID_BIT 58
`define FFE_GUARD_HI 2
`define FFE_SHIFT_MIN (-10)
`define FFE_SHIFT_MAX 7
`define FFE_MATCH_STATE 8'h02
`define FFE_SYNC_LEN 4'h4
`define FFE_CODE_W 4
`define FFE_SEG_HI 55
`define FFE_SEG_LO 40
`define FFE_SEG1_LO 24
`endif

//--- logic/ffe_pkg.sv
// Types shared by the coprocessor front end modules.
package ffe_pkg;
	typedef enum logic [1:0] {FFE_SRC_OBUF, FFE_SRC_STATUS, FFE_SRC_ADDR, FFE_SRC_DATA} ffe_osel_e;
	typedef enum logic [1:0] {FFE_IN_EXCADDR, FFE_IN_EXP, FFE_IN_DATA, FFE_IN_NONE} ffe_isel_e;
	typedef enum logic [2:0] {FFE_OP_NONE, FFE_OP_SHIFT, FFE_OP_COPY_FRAC, FFE_OP_COPY_QUOT,
		FFE_OP_LOAD_BRK, FFE_OP_STORE_STATUS} ffe_op_e;
	typedef enum logic [1:0] {FFE_ST_IDLE, FFE_ST_START, FFE_ST_EXEC, FFE_ST_READY} ffe_state_e;
endpackage

//--- logic/ffe_shift_if.sv
// Shift request and result travelling between the front end and its shifter.
`timescale 1ns/1ps
interface ffe_shift_if;
	logic [6:0] count;
	logic [59:0] frac_in;
	logic [59:0] quot_in;
	logic [59:0] frac_out;
	logic [59:0] quot_out;
	logic supported;
	modport user(output count, output frac_in, output quot_in, input frac_out, input quot_out, input supported);
	modport shifter(input count, input frac_in, input quot_in, output frac_out, output quot_out, output supported);
endinterface

//--- logic/ffe_shifter.sv
// Combinational maintenance shifter for the fraction and quotient registers.
`timescale 1ns/1ps
`include "ffe_consts.svh"
module ffe_shifter
	import ffe_pkg::*;
(
	ffe_shift_if.shifter sh
);
	localparam logic signed [6:0] CNT_MIN = 7'(`FFE_SHIFT_MIN);
	localparam logic signed [6:0] CNT_MAX = 7'(`FFE_SHIFT_MAX);
	logic signed [6:0] cnt;
	logic [3:0] mag;
	assign cnt = sh.count;
	always_comb begin
		sh.supported = (cnt >= CNT_MIN) && (cnt <= CNT_MAX);
		mag = cnt[6] ? 4'((~cnt) + 7'd1) : cnt[3:0];
		if (!sh.supported) begin
			sh.frac_out = sh.frac_in;
			sh.quot_out = sh.quot_in;
		end else if (cnt[6]) begin
			sh.frac_out = sh.frac_in >> mag;
			sh.quot_out = sh.quot_in >> mag;
		end else begin
			sh.frac_out = sh.frac_in << mag;
			sh.quot_out = sh.quot_in << mag;
		end
	end
endmodule

//--- tb/ffe_front_end_properties.sv
// Concurrent checks on the coprocessor front end ports.
`timescale 1ns/1ps
module ffe_chk (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [15:0] cpu_gr3,
	input wire logic [15:0] cpu_gr4,
	input wire logic [2:0] op_req,
	input wire logic op_stb,
	input wire logic instr_done,
	input wire logic [7:0] microstate,
	input wire logic [7:0] exponent_result_reg,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [11:0] instr_exec_reg,
	input wire logic instr_pending,
	input wire logic executing,
	input wire logic [7:0] seq_redirect,
	input wire logic seq_trap,
	input wire logic scope_sync,
	input wire logic [8:0] acc_zero_exp_sign,
	input wire logic shift_bad
);
	logic [7:0] brk_r;
	logic maint_r;
	logic hit;
	logic signed [6:0] cnt;
	assign hit = maint_r && microstate == brk_r;
	assign cnt = cpu_gr4[6:0];
	// Mirror of breakpoint and mode bit; the op wins over a same-cycle write
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			brk_r <= 8'h00;
			maint_r <= 1'b0;
		end else begin
			if (op_stb && op_req == 3'h4) begin
				brk_r <= cpu_gr3[7:0];
			end else if (reg_wr && reg_addr == 4'h1) begin
				brk_r <= reg_wdata[7:0];
			end
			if (reg_wr && reg_addr == 4'h0) begin
				maint_r <= reg_wdata[8];
			end
		end
	end
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	AST_TRAP_SET: assert property (hit |=> seq_trap) else $error("trap missing");
	AST_TRAP_CAUSE: assert property (seq_trap |-> $past(hit)) else $error("trap without match");
	AST_REDIRECT: assert property (seq_trap |-> seq_redirect == 8'h02) else $error("bad redirect");
	AST_SYNC: assert property (seq_trap |-> scope_sync) else $error("sync missing");
	AST_SHIFT_BAD: assert property (op_stb && op_req == 3'h1 && (cnt < -10 || cnt > 7) |=> shift_bad)
		else $error("bad count not flagged");
	AST_COPY_EXP: assert property (op_stb && op_req inside {3'h2, 3'h3} |=>
		acc_zero_exp_sign == {$past(acc_zero_exp_sign[8]), $past(exponent_result_reg)}) else $error("copy exp");
	AST_EXEC_START: assert property ($rose(executing) |-> $past(instr_pending)) else $error("start");
	AST_EXEC_HOLD: assert property (executing && !instr_done |=> executing && $stable(instr_exec_reg))
		else $error("exec changed");
	AST_EXEC_NEXT: assert property (executing && instr_done && instr_pending |-> ##[2:4] executing)
		else $error("next not run");
	cover property (seq_trap);
	cover property ($rose(executing));
	cover property (shift_bad);
endmodule
bind ffe_front_end ffe_chk u_ffe_chk (.*);

//--- tb/ffe_cpu_model.sv
// Host CPU side: strobed loads of instruction, data and address words.
`timescale 1ns/1ps
module ffe_cpu_model (
	input wire logic core_clk,
	output logic cpu_instr_stb,
	output logic cpu_data_stb,
	output logic cpu_addr_stb,
	output logic [15:0] cpu_buffer_reg
);
	logic [2:0] stb = 3'h0;
	initial cpu_buffer_reg = 16'h0000;
	assign {cpu_addr_stb, cpu_data_stb, cpu_instr_stb} = stb;
	// Word held well past the strobe rise because the front end resynchronises it
	task automatic xfer(input int k, input logic [15:0] w);
		@(posedge core_clk);
		cpu_buffer_reg <= (k == 0) ? {~cpu_buffer_reg[15:12], w[11:0]} : w;
		@(posedge core_clk);
		stb[k] <= 1'b1;
		repeat (4) @(posedge core_clk);
		stb <= 3'h0;
		cpu_buffer_reg <= ~w;
	endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench for the coprocessor front end.
`timescale 1ns/1ps
module testbench
	import ffe_pkg::*;
;
	logic core_clk = 1'b0, rstn = 1'b0, cpu_instr_stb, cpu_data_stb, cpu_addr_stb;
	logic op_stb = 1'b0, instr_done = 1'b0, error_evt = 1'b0, frac_load = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [15:0] cpu_buffer_reg, cpu_gr3 = 16'h0000, cpu_gr4 = 16'h0000, obuf = 16'h0000, reg_wdata = 16'h0000;
	logic [2:0] op_req = 3'h0;
	logic [3:0] error_code = 4'h0, reg_addr = 4'h0;
	logic [7:0] microstate = 8'h00, exponent_result_reg = 8'h00, seq_redirect, b;
	logic [1:0] out_sel = 2'h0, in_sel = 2'h0;
	logic [9:0] exp_alu = 10'h000;
	logic [59:0] frac_work_in = 60'h0, quot_in = 60'h0;
	logic [15:0] reg_rdata, data_out_mux, data_in_mux, d, a1, a2;
	logic [11:0] instr_exec_reg;
	logic instr_pending, executing, seq_trap, scope_sync, shift_bad;
	logic [55:0] accumulator_zero;
	logic [8:0] acc_zero_exp_sign;
	logic [63:0] rf, ac;
	logic [59:0] f;
	logic [11:0] q[$];
	logic [31:0] seed = 32'h0001_04CA;
	int fails = 0;
	int n_compared = 0;
	int sh[7] = '{0, 1, -1, 7, -10, 8, -11};
	int bt[7] = '{20, 19, 21, 13, 30, 20, 20};
	ffe_front_end u_ffe_front_end (.*);
	ffe_cpu_model u_ffe_cpu_model (.*);
	always #5 core_clk = ~core_clk;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Rule model of a shift followed by a copy into accumulator zero
	function automatic logic [63:0] acc_model(input logic [59:0] fv, input int s);
		logic [59:0] w;
		w = fv;
		if (s >= -10 && s <= 7) begin
			w = (s < 0) ? (fv >> (-s)) : (fv << s);
		end
		return {8'h00, w[57:3], 1'b0};
	endfunction
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", e, reg_rdata);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic op(input logic [2:0] o, input logic [15:0] g);
		@(posedge core_clk);
		op_req <= o;
		cpu_gr3 <= g;
		op_stb <= 1'b1;
		@(posedge core_clk);
		op_stb <= 1'b0;
	endtask
	task automatic mux(input logic [1:0] o, input logic [1:0] i);
		@(posedge core_clk);
		out_sel <= o;
		in_sel <= i;
		@(posedge core_clk);
		#1;
	endtask
	task automatic done_p();
		@(posedge core_clk);
		instr_done <= 1'b1;
		@(posedge core_clk);
		instr_done <= 1'b0;
	endtask
	task automatic wx();
		int i;
		i = 0;
		do begin
			@(posedge core_clk);
			#1;
			i++;
		end while (executing !== 1'b1 && i < 30);
		chk("executing", 64'h1, 64'(executing));
	endtask
	// Shift then copy back to back, so the copy sees the shifted register
	task automatic cp(input logic [59:0] f, input int s, input logic [2:0] o, output logic [63:0] r);
		@(posedge core_clk);
		frac_work_in <= f;
		quot_in <= f;
		frac_load <= 1'b1;
		exponent_result_reg <= 8'(rnd());
		cpu_gr4 <= {9'h0A5, 7'(s)};
		op_req <= 3'h1;
		@(posedge core_clk);
		frac_load <= 1'b0;
		op_stb <= 1'b1;
		@(posedge core_clk);
		op_req <= o;
		@(posedge core_clk);
		op_stb <= 1'b0;
		#1 r = {8'h00, accumulator_zero};
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		report_and_stop();
	end
	initial begin
		obuf <= 16'(rnd());
		exponent_result_reg <= 8'(rnd());
		exp_alu <= 10'(rnd());
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(4'(i), 16'h0000);
		end
		$display("test reset done");
		d = 16'(rnd());
		a1 = 16'(rnd());
		u_ffe_cpu_model.xfer(1, d);
		u_ffe_cpu_model.xfer(2, a1);
		mux(2'h3, 2'h2);
		chk("data_out_mux", d, data_out_mux);
		chk("data_in_mux", d, data_in_mux);
		mux(2'h2, 2'h3);
		chk("data_out_mux", a1, data_out_mux);
		$display("test cpu loads done");
		for (int k = 0; k < 2; k++) begin
			d = 16'(rnd());
			q.push_back(d[11:0]);
			u_ffe_cpu_model.xfer(0, d);
			if (k == 0) begin
				wx();
				chk("instr_exec_reg", q.pop_front(), instr_exec_reg);
				rd(4'h2, a1);
			end else begin
				rd(4'h4, {4'h1, q[0]});
			end
		end
		a2 = 16'(rnd());
		u_ffe_cpu_model.xfer(2, a2);
		done_p();
		wx();
		chk("instr_exec_reg", q.pop_front(), instr_exec_reg);
		rd(4'h2, a2);
		done_p();
		@(posedge core_clk);
		error_evt <= 1'b1;
		error_code <= 4'hA;
		@(posedge core_clk);
		error_evt <= 1'b0;
		rd(4'h3, 16'h000A);
		rd(4'h5, a2);
		mux(2'h0, 2'h0);
		chk("data_in_mux", a2, data_in_mux);
		chk("data_out_mux", obuf, data_out_mux);
		wr(4'h5, 16'(rnd()));
		rd(4'h5, a2);
		wr(4'hF, 16'(rnd()));
		rd(4'hF, 16'h0000);
		$display("test instructions done");
		d = 16'(rnd());
		b = d[7:0];
		op(3'h4, d);
		rd(4'h1, {8'h00, b});
		wr(4'h0, 16'h0100);
		mux(2'h1, 2'h1);
		chk("data_out_mux", 16'h0100, data_out_mux);
		chk("data_in_mux", {6'h00, exp_alu}, data_in_mux);
		@(posedge core_clk);
		microstate <= b;
		@(posedge core_clk);
		microstate <= ~b;
		#1 chk("seq_trap", 1, seq_trap);
		chk("scope_sync", 1, scope_sync);
		chk("seq_redirect", 8'h02, seq_redirect);
		wr(4'h0, 16'h0000);
		@(posedge core_clk);
		microstate <= b;
		@(posedge core_clk);
		microstate <= ~b;
		#1 chk("seq_trap", 0, seq_trap);
		chk("scope_sync", 1, scope_sync);
		repeat (4) @(posedge core_clk);
		#1 chk("scope_sync", 1, scope_sync);
		@(posedge core_clk);
		#1 chk("scope_sync", 0, scope_sync);
		$display("test breakpoint done");
		for (int o = 2; o < 4; o++) begin
			cp(60'h1 << 20, 0, 3'(o), rf);
			chk("acc ones", 1, $countones(rf));
			chk("accumulator_zero", 64'h1 << 18, rf);
			for (int i = 0; i < 7; i++) begin
				f = (60'h1 << bt[i]) | (i == 0 ? 60'hC00_0000_0000_0007 : 60'h0);
				cp(f, sh[i], 3'(o), ac);
				chk("accumulator_zero", acc_model(f, sh[i]), ac);
				chk("acc_zero_exp_sign", {55'h0, 1'b0, exponent_result_reg}, 64'(acc_zero_exp_sign));
				if (o == 2 || i > 4) begin
					chk("shift_bad", i > 4, shift_bad);
				end
			end
		end
		$display("test shift and copy done");
		report_and_stop();
	end
endmodule
